/* File: sfp_regs.svh */
`ifndef SFP_REGS_SVH
`define SFP_REGS_SVH

// ==========================================================
// Timing
`define SFP_CLK_NS         8
`define SFP_ADDR_SETUP_NS  25
`define SFP_RD_LOW_NS      50
`define SFP_RD_HIGH_NS     50
`define SFP_WR_LOW_NS      50
`define SFP_WR_HIGH_NS     70
`define SFP_COMMIT_LOW_NS  50
`define SFP_COMMIT_HIGH_NS 50
// Least time rounded up to whole clock cycles
`define SFP_CYC(ns) (((ns) + `SFP_CLK_NS - 1) / `SFP_CLK_NS)

// ==========================================================
// Reset values
`define SFP_STATE_RESET '0

`endif

/* File: sfp_pkg.sv */
package sfp_pkg;

  // ==========================================================
  // Widths and depths
  localparam int SFP_DW    = 16;
  localparam int SFP_DEPTH = 16;
  localparam int SFP_AW    = 4;
  localparam int SFP_NFIFO = 4;
  localparam int SFP_CW    = 4;

  typedef logic [SFP_DW-1:0] sfp_word_t;
  typedef logic [SFP_AW:0]   sfp_ptr_t;
  typedef logic [1:0]        sfp_fifo_t;
  typedef logic [2:0]        sfp_sel_t;

  localparam sfp_ptr_t SFP_FULL_LEVEL = sfp_ptr_t'(SFP_DEPTH);

  // ==========================================================
  // Master commands and phases
  typedef enum logic [1:0] {SFP_CMD_READ, SFP_CMD_WRITE, SFP_CMD_COMMIT} sfp_cmd_t;
  typedef enum logic [1:0] {SFP_IDLE, SFP_SETUP, SFP_ACTIVE, SFP_RECOVER} sfp_phase_t;

  // ==========================================================
  // Device state
  typedef struct packed {
    sfp_word_t [SFP_NFIFO-1:0][SFP_DEPTH-1:0] mem;
    sfp_ptr_t [SFP_NFIFO-1:0]                 wrPtr;
    sfp_ptr_t [SFP_NFIFO-1:0]                 rdPtr;
    sfp_ptr_t [SFP_NFIFO-1:0]                 pktCount;
    logic                                     ifClkPrev;
    logic                                     rdPrevOn;
    logic                                     wrPrevOn;
    logic                                     commitPrevOn;
    sfp_word_t                                busOut;
    logic                                     hasData;
    logic                                     noRoom;
    logic                                     commitValid;
    sfp_fifo_t                                commitFifo;
    sfp_ptr_t                                 commitCount;
    logic                                     commitAuto;
  } sfp_dev_state_t;

  // ==========================================================
  // Master state
  typedef struct packed {
    logic [1:0]        div;
    sfp_phase_t        phase;
    logic [SFP_CW-1:0] count;
    sfp_cmd_t          kind;
    sfp_sel_t          sel;
    sfp_word_t         data;
    logic              csOn;
    logic              oeOn;
    logic              rdOn;
    logic              wrOn;
    logic              commitOn;
    logic              driveOn;
    logic              rspValid;
    sfp_word_t         rspData;
  } sfp_mst_state_t;

endpackage

/* File: sfp_link_if.sv */
`timescale 1ns/1ps
interface sfp_link_if
  import sfp_pkg::*;
;
  logic      interfaceClock;
  logic      slaveChipSelectN;
  logic      slaveOutputEnableN;
  logic      slaveReadStrobeN;
  logic      slaveWriteStrobeN;
  logic      packetCommitStrobeN;
  sfp_sel_t  fifoSelectBus;
  sfp_word_t devData;
  logic      devDataOeN;
  sfp_word_t mstData;
  logic      mstDataOeN;
  sfp_word_t busData;
  logic      flagEmpty;
  logic      flagFull;

  // ==========================================================
  // Shared data bus, pulled high when nobody drives
  assign busData = !devDataOeN ? devData : (!mstDataOeN ? mstData : '1);

  modport device (
    input  interfaceClock,
    input  slaveChipSelectN,
    input  slaveOutputEnableN,
    input  slaveReadStrobeN,
    input  slaveWriteStrobeN,
    input  packetCommitStrobeN,
    input  fifoSelectBus,
    input  busData,
    output devData,
    output devDataOeN,
    output flagEmpty,
    output flagFull
  );

  modport master (
    output interfaceClock,
    output slaveChipSelectN,
    output slaveOutputEnableN,
    output slaveReadStrobeN,
    output slaveWriteStrobeN,
    output packetCommitStrobeN,
    output fifoSelectBus,
    output mstData,
    output mstDataOeN,
    input  busData,
    input  flagEmpty,
    input  flagFull
  );
endinterface

/* File: sfp_master.sv */
`timescale 1ns/1ps
`include "sfp_regs.svh"
module sfp_master
  import sfp_pkg::*;
(
  input  logic      clk,
  input  logic      reset,
  input  logic      clkEnable,
  input  logic      syncMode,
  input  logic      cmdValid,
  input  sfp_cmd_t  cmdKind,
  input  sfp_sel_t  cmdFifo,
  input  sfp_word_t cmdData,
  output logic      cmdReady,
  output logic      rspValid,
  output sfp_word_t rspData,
  sfp_link_if.master link
);

  localparam logic [SFP_CW-1:0] ADDR_CYC   = SFP_CW'(`SFP_CYC(`SFP_ADDR_SETUP_NS) - 1);
  localparam logic [SFP_CW-1:0] RD_LOW     = SFP_CW'(`SFP_CYC(`SFP_RD_LOW_NS) - 1);
  localparam logic [SFP_CW-1:0] RD_HIGH    = SFP_CW'(`SFP_CYC(`SFP_RD_HIGH_NS) - 1);
  localparam logic [SFP_CW-1:0] WR_LOW     = SFP_CW'(`SFP_CYC(`SFP_WR_LOW_NS) - 1);
  localparam logic [SFP_CW-1:0] WR_HIGH    = SFP_CW'(`SFP_CYC(`SFP_WR_HIGH_NS) - 1);
  localparam logic [SFP_CW-1:0] CMT_LOW    = SFP_CW'(`SFP_CYC(`SFP_COMMIT_LOW_NS) - 1);
  localparam logic [SFP_CW-1:0] CMT_HIGH   = SFP_CW'(`SFP_CYC(`SFP_COMMIT_HIGH_NS) - 1);

  sfp_mst_state_t s;
  sfp_mst_state_t next_s;
  logic           fallPoint;
  logic           flagOk;
  logic           burstOk;

  // ==========================================================
  // Next state
  always_comb
  begin
    next_s = s;
    next_s.rspValid = 1'b0;
    next_s.div = s.div + 2'd1;
    cmdReady = 1'b0;
    // In sync mode the strobes change only as the interface clock falls
    fallPoint = (s.div == 2'd3);
    unique case (s.kind)
      SFP_CMD_READ:   flagOk = ~link.flagEmpty;
      SFP_CMD_WRITE:  flagOk = ~link.flagFull;
      SFP_CMD_COMMIT: flagOk = 1'b1;
      default:        flagOk = 1'b0;
    endcase
    burstOk = cmdValid && (cmdKind == s.kind) && (cmdFifo == s.sel)
              && (s.kind != SFP_CMD_COMMIT) && flagOk;
    unique case (s.phase)
      SFP_IDLE:
      begin
        cmdReady = 1'b1;
        if (cmdValid)
        begin
          next_s.kind = cmdKind;
          next_s.sel = cmdFifo;
          next_s.data = cmdData;
          next_s.csOn = 1'b1;
          next_s.driveOn = (cmdKind == SFP_CMD_WRITE);
          next_s.oeOn = syncMode && (cmdKind == SFP_CMD_READ);
          next_s.count = ADDR_CYC;
          next_s.phase = SFP_SETUP;
        end
      end
      SFP_SETUP:
      begin
        if (s.count != '0)
        begin
          next_s.count = s.count - 1'b1;
        end
        else if (flagOk && (fallPoint || !syncMode))
        begin
          next_s.phase = SFP_ACTIVE;
          next_s.rdOn = (s.kind == SFP_CMD_READ);
          next_s.wrOn = (s.kind == SFP_CMD_WRITE);
          next_s.commitOn = (s.kind == SFP_CMD_COMMIT);
          if (!syncMode && s.kind == SFP_CMD_READ)
          begin
            next_s.oeOn = 1'b1;
          end
          unique case (s.kind)
            SFP_CMD_READ:  next_s.count = RD_LOW;
            SFP_CMD_WRITE: next_s.count = WR_LOW;
            default:       next_s.count = CMT_LOW;
          endcase
        end
      end
      SFP_ACTIVE:
      begin
        if (syncMode)
        begin
          if (s.div == 2'd1 && s.kind == SFP_CMD_READ)
          begin
            next_s.rspData = link.busData;
          end
          if (fallPoint)
          begin
            next_s.rspValid = (s.kind != SFP_CMD_COMMIT);
            if (burstOk)
            begin
              // Strobes stay asserted across the next edge
              cmdReady = 1'b1;
              next_s.data = cmdData;
            end
            else
            begin
              next_s.rdOn = 1'b0;
              next_s.wrOn = 1'b0;
              next_s.commitOn = 1'b0;
              next_s.count = '0;
              next_s.phase = SFP_RECOVER;
            end
          end
        end
        else if (s.count != '0)
        begin
          next_s.count = s.count - 1'b1;
        end
        else
        begin
          if (s.kind == SFP_CMD_READ)
          begin
            next_s.rspData = link.busData;
          end
          next_s.rspValid = (s.kind != SFP_CMD_COMMIT);
          next_s.rdOn = 1'b0;
          next_s.wrOn = 1'b0;
          next_s.commitOn = 1'b0;
          next_s.oeOn = 1'b0;
          unique case (s.kind)
            SFP_CMD_READ:  next_s.count = RD_HIGH;
            SFP_CMD_WRITE: next_s.count = WR_HIGH;
            default:       next_s.count = CMT_HIGH;
          endcase
          next_s.phase = SFP_RECOVER;
        end
      end
      SFP_RECOVER:
      begin
        if (s.count != '0)
        begin
          next_s.count = s.count - 1'b1;
        end
        else
        begin
          // Commit never shares an edge with a write
          next_s.csOn = 1'b0;
          next_s.oeOn = 1'b0;
          next_s.driveOn = 1'b0;
          next_s.phase = SFP_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s <= `SFP_STATE_RESET;
    end
    else if (clkEnable)
    begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Link drive
  assign link.interfaceClock      = s.div[1];
  assign link.slaveChipSelectN    = ~s.csOn;
  assign link.slaveOutputEnableN  = ~s.oeOn;
  assign link.slaveReadStrobeN    = ~s.rdOn;
  assign link.slaveWriteStrobeN   = ~s.wrOn;
  assign link.packetCommitStrobeN = ~s.commitOn;
  assign link.fifoSelectBus       = s.sel;
  assign link.mstData             = s.data;
  assign link.mstDataOeN          = ~s.driveOn;
  assign rspValid                 = s.rspValid;
  assign rspData                  = s.rspData;

endmodule

/* File: sfp_device.sv */
// Contract
// - Output enable drives prefetched word, no advance
// - Master asserts select with or before read
// - Sync read advances pointer each clock edge
// - Sync burst read: strobes held, pointer increments
// - Data bus driven only while enable asserted
// - Address stable 25 ns before sampling edge
// - Sync write data set up before edge
// - Sync write stores word, increments, updates flags
// - Sync burst write captures word every edge
// - Commit strobe commits packet, same-edge word included
// - Select address held during commit strobe
// - Auto mode: one-word commit one clock later
// - Auto mode commits at programmed length
// - Async enable drives previous read word
// - Async read strobe widths; select first
// - Async read strobe low/high 50 ns
// - Async read edge loads data, then increments
// - Read strobe and enable may be tied
// - Async write data setup, strobe widths met
// - Async write release stores, post-increments, flags
// - Async commit never overlaps write strobe
// - Flags and data follow selected FIFO
// - Select may be held permanently asserted
`timescale 1ns/1ps
`include "sfp_regs.svh"
module sfp_device
  import sfp_pkg::*;
(
  input  logic      clk,
  input  logic      reset,
  input  logic      clkEnable,
  input  logic      syncMode,
  input  logic      autoCommit,
  input  sfp_ptr_t  autoCommitLength,
  input  logic      usbPushValid,
  input  sfp_fifo_t usbPushFifo,
  input  sfp_word_t usbPushData,
  output logic      usbPushReady,
  output logic      commitValid,
  output sfp_fifo_t commitFifo,
  output sfp_ptr_t  commitCount,
  output logic      commitAuto,
  sfp_link_if.device link
);

  sfp_dev_state_t s;
  sfp_dev_state_t next_s;
  sfp_fifo_t      f;
  logic           selOk;
  logic           csOn;
  logic           rdOn;
  logic           wrOn;
  logic           commitOn;
  logic           ifRise;
  logic           doRd;
  logic           doWr;
  logic           doCommit;
  logic           wrTaken;
  logic           autoHit;
  sfp_ptr_t       level;
  sfp_ptr_t       newLevel;
  sfp_ptr_t       pushLevel;
  sfp_ptr_t       pkt;

  // ==========================================================
  // Next state
  always_comb
  begin
    next_s = s;
    next_s.commitValid = 1'b0;
    f = link.fifoSelectBus[1:0];
    selOk = ~link.fifoSelectBus[2];
    csOn = ~link.slaveChipSelectN;
    rdOn = ~link.slaveReadStrobeN;
    wrOn = ~link.slaveWriteStrobeN;
    commitOn = ~link.packetCommitStrobeN;
    ifRise = link.interfaceClock & ~s.ifClkPrev;
    next_s.ifClkPrev = link.interfaceClock;
    next_s.rdPrevOn = rdOn;
    next_s.wrPrevOn = wrOn;
    next_s.commitPrevOn = commitOn;

    // Strobe qualification per mode
    if (syncMode)
    begin
      doRd = ifRise & csOn & rdOn;
      doWr = ifRise & csOn & wrOn;
      doCommit = ifRise & csOn & commitOn;
    end
    else
    begin
      doRd = csOn & rdOn & ~s.rdPrevOn;
      doWr = csOn & ~wrOn & s.wrPrevOn;
      doCommit = csOn & commitOn & ~s.commitPrevOn;
    end

    level = s.wrPtr[f] - s.rdPtr[f];
    wrTaken = doWr & selOk & (level != SFP_FULL_LEVEL);
    pkt = s.pktCount[f];

    // ==========================================================
    // Master read
    if (doRd && selOk && level != '0)
    begin
      if (!syncMode)
      begin
        next_s.busOut = s.mem[f][s.rdPtr[f][SFP_AW-1:0]];
      end
      next_s.rdPtr[f] = s.rdPtr[f] + 1'b1;
    end

    // ==========================================================
    // Master write, pointer post-incremented
    if (wrTaken)
    begin
      next_s.mem[f][s.wrPtr[f][SFP_AW-1:0]] = link.busData;
      next_s.wrPtr[f] = s.wrPtr[f] + 1'b1;
      pkt = pkt + 1'b1;
    end
    next_s.pktCount[f] = pkt;

    // ==========================================================
    // Packet commit, manual or automatic
    autoHit = autoCommit & wrTaken & (pkt == autoCommitLength);
    if ((doCommit & selOk) | autoHit)
    begin
      next_s.commitValid = 1'b1;
      next_s.commitFifo = f;
      next_s.commitCount = pkt;
      next_s.commitAuto = ~(doCommit & selOk);
      next_s.pktCount[f] = '0;
      // Committed words leave the buffer
      next_s.rdPtr[f] = next_s.wrPtr[f];
    end

    // ==========================================================
    // USB-side fill, yields to a master write on the same FIFO
    pushLevel = next_s.wrPtr[usbPushFifo] - next_s.rdPtr[usbPushFifo];
    usbPushReady = (pushLevel != SFP_FULL_LEVEL) && !(wrTaken && f == usbPushFifo);
    if (usbPushValid && usbPushReady)
    begin
      next_s.mem[usbPushFifo][next_s.wrPtr[usbPushFifo][SFP_AW-1:0]] = usbPushData;
      next_s.wrPtr[usbPushFifo] = next_s.wrPtr[usbPushFifo] + 1'b1;
    end

    // ==========================================================
    // Prefetch and flags of the selected FIFO
    if (syncMode)
    begin
      next_s.busOut = next_s.mem[f][next_s.rdPtr[f][SFP_AW-1:0]];
    end
    newLevel = next_s.wrPtr[f] - next_s.rdPtr[f];
    next_s.hasData = selOk & (newLevel != '0);
    next_s.noRoom = ~selOk | (newLevel == SFP_FULL_LEVEL);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s <= `SFP_STATE_RESET;
    end
    else if (clkEnable)
    begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs
  assign link.devData    = s.busOut;
  assign link.devDataOeN = link.slaveOutputEnableN;
  assign link.flagEmpty  = ~s.hasData;
  assign link.flagFull   = s.noRoom;
  assign commitValid     = s.commitValid;
  assign commitFifo      = s.commitFifo;
  assign commitCount     = s.commitCount;
  assign commitAuto      = s.commitAuto;

endmodule

/* File: sfp_link_sva.sv */
`timescale 1ns/1ps
module sfp_link_sva
  import sfp_pkg::*;
(
  input logic     clk,
  input logic     reset,
  input logic     syncMode,
  input logic     autoCommit,
  input logic     interfaceClock,
  input logic     slaveChipSelectN,
  input logic     slaveOutputEnableN,
  input logic     slaveReadStrobeN,
  input logic     slaveWriteStrobeN,
  input logic     packetCommitStrobeN,
  input sfp_sel_t fifoSelectBus,
  input sfp_word_t devData,
  input logic     devDataOeN,
  input logic     flagEmpty,
  input logic     flagFull
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // ==========================================================
  // Bus drive
  a_oe_drives_bus: assert property (!slaveOutputEnableN |-> !devDataOeN)
    else $error("data bus not driven under output enable");
  a_bus_released: assert property (slaveOutputEnableN |-> devDataOeN)
    else $error("data bus driven without output enable");
  a_oe_holds_head: assert property (!slaveOutputEnableN && $past(!slaveOutputEnableN)
    && slaveReadStrobeN && $past(slaveReadStrobeN) && !flagEmpty && $past(!flagEmpty)
    && $past(fifoSelectBus) == $past(fifoSelectBus, 2) |-> $stable(devData))
    else $error("head word moved under output enable alone");

  // ==========================================================
  // Master strobes
  a_cs_with_strobe: assert property (($fell(slaveReadStrobeN) || $fell(slaveWriteStrobeN))
    |-> !slaveChipSelectN)
    else $error("strobe asserted before chip select");
  a_addr_setup: assert property (($fell(slaveReadStrobeN) || $fell(slaveWriteStrobeN))
    |-> fifoSelectBus == $past(fifoSelectBus, 4))
    else $error("fifo select changed inside setup time");
  a_rd_low_width: assert property (!syncMode && $fell(slaveReadStrobeN)
    |-> (!slaveReadStrobeN)[*7])
    else $error("read strobe low too short");
  a_rd_high_width: assert property (!syncMode && $rose(slaveReadStrobeN)
    |-> slaveReadStrobeN[*7])
    else $error("read strobe high too short");
  a_no_wr_commit: assert property (!syncMode |-> slaveWriteStrobeN || packetCommitStrobeN)
    else $error("write and commit strobes overlap");
  a_commit_addr: assert property (!packetCommitStrobeN && $past(!packetCommitStrobeN)
    |-> $stable(fifoSelectBus))
    else $error("fifo select moved during commit");

  // ==========================================================
  // Flags after transfers
  a_sync_wr_flag: assert property (syncMode && !autoCommit && $rose(interfaceClock)
    && !slaveChipSelectN && !slaveWriteStrobeN && !flagFull && !fifoSelectBus[2]
    |-> ##[1:2] !flagEmpty)
    else $error("flags not updated after sync write");
  a_async_wr_flag: assert property (!syncMode && !autoCommit && $rose(slaveWriteStrobeN)
    && !slaveChipSelectN && !flagFull && !fifoSelectBus[2] |-> ##[1:2] !flagEmpty)
    else $error("flags not updated after async write");
  a_commit_empties: assert property (((syncMode && $rose(interfaceClock)
    && !packetCommitStrobeN) || (!syncMode && $fell(packetCommitStrobeN)))
    && !fifoSelectBus[2] |-> ##[1:2] flagEmpty)
    else $error("fifo not emptied by commit");
  a_flag_excl: assert property (!fifoSelectBus[2] |-> !(flagEmpty && flagFull))
    else $error("mapped fifo shows empty and full");
endmodule

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench
  import sfp_pkg::*;
;
  logic        clk, reset, syncMode, autoCommit, cmdValid, cmdReady, rspValid;
  logic        usbPushValid, usbPushReady, commitValid, commitAuto;
  sfp_cmd_t    cmdKind;
  sfp_sel_t    cmdFifo;
  sfp_word_t   cmdData, rspData, usbPushData, lfsr;
  sfp_fifo_t   usbPushFifo, commitFifo;
  sfp_ptr_t    autoCommitLength, commitCount;
  sfp_word_t   rdq[4][$];
  logic [16:0] expR[$];
  logic [7:0]  expC[$];
  int          n_fail, comparisons, cycles, wcnt[4];

  sfp_link_if link ();
  sfp_master u_sfp_master (.clk(clk), .reset(reset), .clkEnable(1'b1), .syncMode(syncMode),
    .cmdValid(cmdValid), .cmdKind(cmdKind), .cmdFifo(cmdFifo), .cmdData(cmdData),
    .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData), .link(link));
  sfp_device u_sfp_device (.clk(clk), .reset(reset), .clkEnable(1'b1), .syncMode(syncMode),
    .autoCommit(autoCommit), .autoCommitLength(autoCommitLength),
    .usbPushValid(usbPushValid), .usbPushFifo(usbPushFifo), .usbPushData(usbPushData),
    .usbPushReady(usbPushReady), .commitValid(commitValid), .commitFifo(commitFifo),
    .commitCount(commitCount), .commitAuto(commitAuto), .link(link));
  sfp_link_sva u_sfp_link_sva (.clk(clk), .reset(reset), .syncMode(syncMode),
    .autoCommit(autoCommit), .interfaceClock(link.interfaceClock),
    .slaveChipSelectN(link.slaveChipSelectN), .slaveOutputEnableN(link.slaveOutputEnableN),
    .slaveReadStrobeN(link.slaveReadStrobeN), .slaveWriteStrobeN(link.slaveWriteStrobeN),
    .packetCommitStrobeN(link.packetCommitStrobeN), .fifoSelectBus(link.fifoSelectBus),
    .devData(link.devData), .devDataOeN(link.devDataOeN), .flagEmpty(link.flagEmpty),
    .flagFull(link.flagFull));

  // ==========================================================
  // Helpers
  function automatic sfp_word_t rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic finish_test();
    if (n_fail == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Valid stays up after the take so a following call continues a burst in sync mode
  task automatic cmd(sfp_cmd_t k, sfp_sel_t f, sfp_word_t d);
    @(negedge clk);
    cmdValid = 1'b1;
    cmdKind = k;
    cmdFifo = f;
    cmdData = d;
    // Let the ready term settle on the new request
    #1;
    while (cmdReady !== 1'b1)
      @(negedge clk);
    if (k == SFP_CMD_READ)
      expR.push_back({1'b1, rdq[f].pop_front()});
    else if (k == SFP_CMD_WRITE)
    begin
      expR.push_back({1'b0, d});
      rdq[f].push_back(d);
      wcnt[f]++;
      if (autoCommit && wcnt[f] == int'(autoCommitLength))
      begin
        expC.push_back({1'b1, f[1:0], autoCommitLength});
        wcnt[f] = 0;
        rdq[f].delete();
      end
    end
    else
    begin
      expC.push_back({1'b0, f[1:0], sfp_ptr_t'(wcnt[f])});
      wcnt[f] = 0;
      rdq[f].delete();
    end
  endtask

  task automatic endc();
    @(negedge clk);
    cmdValid = 1'b0;
  endtask

  task automatic push(sfp_fifo_t f, sfp_word_t d);
    @(negedge clk);
    usbPushValid = 1'b1;
    usbPushFifo = f;
    usbPushData = d;
    #1;
    while (usbPushReady !== 1'b1)
      @(negedge clk);
    rdq[f].push_back(d);
    @(negedge clk);
    usbPushValid = 1'b0;
  endtask

  task automatic drain();
    for (int i = 0; i < 400 && (expR.size() > 0 || expC.size() > 0); i++)
      @(negedge clk);
    repeat (8) @(negedge clk);
  endtask

  // ==========================================================
  // Result monitors
  always @(negedge clk)
  begin
    if (rspValid === 1'b1)
    begin
      if (expR[0][16])
        chk("rspData", expR[0][15:0], rspData);
      void'(expR.pop_front());
    end
    if (commitValid === 1'b1)
    begin
      chk("commit", 16'(expC[0]), 16'({commitAuto, commitFifo, commitCount}));
      void'(expC.pop_front());
    end
  end

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_fail++;
      finish_test();
    end
  end

  // ==========================================================
  // Main sequence: sync pass, then async pass
  initial
  begin
    reset = 1'b1;
    syncMode = 1'b1;
    autoCommit = 1'b0;
    autoCommitLength = 5'h03;
    cmdValid = 1'b0;
    cmdKind = SFP_CMD_READ;
    cmdFifo = 3'h0;
    cmdData = 16'h0000;
    usbPushValid = 1'b0;
    usbPushFifo = 2'h0;
    usbPushData = 16'h0000;
    lfsr = 16'h853A;
    repeat (16) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    for (int m = 0; m < 2; m++)
    begin
      syncMode = (m == 0);
      autoCommitLength = 5'(3 + m);
      for (int i = 0; i < 16 - 11 * m; i++)
        push(2'(2 + m), rnd());
      for (int i = 0; i < 16 - 11 * m; i++)
        cmd(SFP_CMD_READ, 3'(2 + m), 16'h0000);
      endc();
      for (int i = 0; i < 4; i++)
        cmd(SFP_CMD_WRITE, 3'h0, rnd());
      endc();
      for (int i = 0; i < 2; i++)
        cmd(SFP_CMD_READ, 3'h0, 16'h0000);
      endc();
      cmd(SFP_CMD_COMMIT, 3'h0, 16'h0000);
      endc();
      drain();
      autoCommit = 1'b1;
      for (int i = 0; i < 3 + m; i++)
        cmd(SFP_CMD_WRITE, 3'h1, rnd());
      endc();
      drain();
      cmd(SFP_CMD_WRITE, 3'h1, rnd());
      endc();
      cmd(SFP_CMD_COMMIT, 3'h1, 16'h0000);
      endc();
      drain();
      autoCommit = 1'b0;
    end
    chk("rspLeft", 16'h0000, 16'(expR.size()));
    chk("commitLeft", 16'h0000, 16'(expC.size()));
    finish_test();
  end
endmodule
